// ==== shared/obl_pkg.sv ====
// package for the option byte loader: field positions, reset values, decoded types
package obl_pkg;
  // byte indices within the option store
  localparam int unsigned OPT_BOOT_DEBUG   = 0;          // boot/debug/reset-pin/protection byte
  localparam int unsigned OPT_LOADER_SIZE  = 1;          // loader area size byte
  localparam int unsigned OPT_BROWNOUT     = 2;          // brown-out byte
  localparam int unsigned OPT_WATCHDOG     = 4;          // watchdog byte
  localparam int unsigned OPT_COUNT        = 5;          // bytes held in the store
  // field positions, boot/debug byte
  localparam int unsigned BIT_BOOT_SEL     = 7;
  localparam int unsigned BIT_PWM_FLOAT    = 5;
  localparam int unsigned BIT_DEBUG_EN_N   = 4;
  localparam int unsigned BIT_RESET_PIN    = 2;
  localparam int unsigned BIT_READ_PROT_N  = 1;
  // field positions, brown-out byte
  localparam int unsigned BIT_BOD_ON       = 7;
  localparam int unsigned BIT_BOD_LVL_HI   = 5;
  localparam int unsigned BIT_BOD_LVL_LO   = 4;
  localparam int unsigned BIT_BOD_SELFPROG = 3;
  localparam int unsigned BIT_BOD_RESET    = 2;
  // field positions, loader size and watchdog bytes
  localparam int unsigned BIT_LDR_HI       = 2;
  localparam int unsigned BIT_WDT_HI       = 7;
  localparam int unsigned BIT_WDT_LO       = 4;
  // writable masks: reserved bits stay at one
  localparam logic [7:0] MASK_BOOT_DEBUG   = 8'hb6;
  localparam logic [7:0] MASK_LOADER_SIZE  = 8'h07;
  localparam logic [7:0] MASK_BROWNOUT     = 8'hbc;
  localparam logic [7:0] MASK_WATCHDOG     = 8'hf0;
  localparam logic [7:0] MASK_UNUSED       = 8'h00;
  // erased value of an option byte
  localparam logic [7:0] OPT_ERASED        = 8'hff;
  localparam logic [7:0] FLASH_BLANK       = 8'hff;
  // watchdog codes
  localparam logic [3:0] WDT_CODE_OFF      = 4'hf;
  localparam logic [3:0] WDT_CODE_STOPIDLE = 4'h5;
  // loader sizes in KiB and total program space
  localparam logic [4:0] FLASH_TOTAL_KB    = 5'h10;
  localparam logic [2:0] LDR_CODE_NONE     = 3'h7;
  localparam logic [2:0] LDR_CODE_1K       = 3'h6;
  localparam logic [2:0] LDR_CODE_2K       = 3'h5;
  localparam logic [2:0] LDR_CODE_3K       = 3'h4;
  localparam logic [4:0] LDR_KB_MAX        = 5'h04;
  // brown-out threshold in tenths of a volt
  localparam logic [5:0] BOD_MV_11         = 6'h16;  // 2.2 V
  localparam logic [5:0] BOD_MV_10         = 6'h1b;  // 2.7 V
  localparam logic [5:0] BOD_MV_01         = 6'h25;  // 3.7 V
  localparam logic [5:0] BOD_MV_00         = 6'h2c;  // 4.4 V

  // programming port operations
  typedef enum logic [1:0] {OBL_OP_NONE, OBL_OP_READ, OBL_OP_PROGRAM, OBL_OP_CHIP_ERASE} obl_op_e;
  // watchdog start-up modes
  typedef enum logic [1:0] {OBL_WDT_TIMER, OBL_WDT_RESET_STOPIDLE, OBL_WDT_RESET_RUN} obl_wdt_e;

  // programmer request: to option byte or to main flash
  typedef struct packed {
    obl_op_e    op;        // operation
    logic       to_option; // 1 = option byte, 0 = main flash
    logic [2:0] index;     // option byte index
    logic [7:0] wdata;     // programmed data
  } obl_prog_req_s;

  // decoded options toward consumers
  typedef struct packed {
    logic       boot_from_app;    // restart block select
    logic       pwm_float_halt;   // float pwm pins on debug halt
    logic       debug_port_on;    // debug port enabled
    logic       reset_pin_is_rst; // shared pin is external reset
    logic       read_protected;   // programmer reads blank
    logic [4:0] loader_kb;        // loader area size
    logic [4:0] app_kb;           // application area size
    logic       bod_on;           // brown-out detector on
    logic [5:0] bod_level_dv;     // threshold in tenths of a volt
    logic       bod_reset_on;     // reset on brown-out
    logic       bod_blocks_prog;  // selfprog inhibited by brown-out
    obl_wdt_e   wdt_mode;         // watchdog start-up mode
  } obl_options_s;
endpackage : obl_pkg

// ==== rtl/obl_option_loader.sv ====
// option byte store, reset-time loader and decoder
`timescale 1ns/1ps
// Functional notes
// (R01) reset copies options into software control bits
// (R02) programmer keeps reserved option bits unprogrammed
// (R03) bit seven picks restart block, not soft
// (R04) halt floats pwm if bit five set
// (R05) pwm float only on pwm-selected channels
// (R06) bit four low enables debug port
// (R07) debug with port enabled: flag only
// (R08) bit two picks reset or input pin
// (R09) protected: reads give FFH, programming rejected
// (R10) options readable, not individually writable when protected
// (R11) only whole-chip erase removes protection; a sw_we write setting sw_ctrl bit one also clears it here
// (R12) protection leaves in-app programming alone
// (R13) three-bit field sets loader area size
// (R14) brown-out byte bit seven enables detector
// (R15) two-bit field selects brown-out threshold
// (R16) brown-out may block selfprog below threshold
// (R17) brown-out byte bit two enables reset
// (R18) four-bit code picks watchdog start mode
// (R19) boot/debug byte reloads on every reset
// (R20) brown-out byte reloads on power-on only
// (R21) erased option bits read as one
module obl_option_loader (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  por_event,        // reset cause is power-on
  input  wire logic                  soft_reset_event, // reset cause is software
  // programmer port (external writer or in-circuit)
  input  wire obl_pkg::obl_prog_req_s prog_req,
  output logic                       prog_ack,
  output logic                       prog_reject,
  output logic [7:0]                 prog_rdata,
  input  wire logic [7:0]            flash_rdata,      // raw main flash byte
  output logic                       flash_read_en,
  output logic                       flash_write_en,
  output logic                       flash_chip_erase,
  // in-app programming port
  input  wire logic                  iap_req,
  input  wire logic                  iap_is_write,     // erase or program
  output logic                       iap_grant,
  output logic                       iap_blocked,
  // software control bits
  input  wire logic                  sw_we,
  input  wire logic [7:0]            sw_wdata,
  output logic [7:0]                 sw_ctrl,          // working copy of boot/debug byte
  // system status
  input  wire logic                  supply_below_bod,
  input  wire logic                  debug_mode,
  input  wire logic                  hard_fault,
  input  wire logic                  debug_halt,
  input  wire logic [7:0]            pwm_pin_select,
  input  wire logic [7:0]            pwm_out_raw,
  // consumer side
  output obl_pkg::obl_options_s      options,
  output logic                       hard_fault_reset,
  output logic                       hard_fault_flag,
  output logic                       brownout_reset,
  output logic [7:0]                 pwm_out,
  output logic [7:0]                 pwm_oe
);
  import obl_pkg::*;

  logic [7:0] store_reg [OPT_COUNT];   // nonvolatile option bytes
  logic [7:0] bod_work_reg;            // working copy of brown-out byte
  logic       boot_from_app_reg;       // latched restart block
  logic       rst_d_reg;               // reset seen last cycle
  logic       hf_flag_reg;             // sticky hard-fault flag
  logic [7:0] rdata_reg;               // programmer read data
  logic       ack_reg;
  logic       rej_reg;
  logic       protected_w;             // read protection active
  logic [7:0] mask_w;                  // writable bits of addressed byte
  logic       is_prog;
  logic       is_read;
  logic       is_erase;
  logic       ld_release;

  assign protected_w = ~sw_ctrl[BIT_READ_PROT_N];
  assign is_prog     = prog_req.op == OBL_OP_PROGRAM;
  assign is_read     = prog_req.op == OBL_OP_READ;
  assign is_erase    = prog_req.op == OBL_OP_CHIP_ERASE;
  assign ld_release  = rst_d_reg & ~rst;

  // writable mask per byte; reserved bits never move
  always_comb begin
    unique case (prog_req.index)
      3'h0:    mask_w = MASK_BOOT_DEBUG;
      3'h1:    mask_w = MASK_LOADER_SIZE;
      3'h2:    mask_w = MASK_BROWNOUT;
      3'h4:    mask_w = MASK_WATCHDOG;
      default: mask_w = MASK_UNUSED;
    endcase
  end

  // nonvolatile store; not cleared by any reset, only by chip erase
  // flash programs bits only toward zero, so program is an and
  always_ff @(posedge mclk) begin
    if (is_erase) begin
      for (int i = 0; i < OPT_COUNT; i++) begin
        store_reg[i] <= OPT_ERASED; // [R11] [R21]
      end
    end else if (is_prog && prog_req.to_option && !protected_w
                 && prog_req.index < 3'(OPT_COUNT)) begin // [R10]
      store_reg[prog_req.index] <= store_reg[prog_req.index] & (prog_req.wdata | ~mask_w); // [R02]
    end
  end

  // release edge detect for loading after reset
  always_ff @(posedge mclk) begin
    rst_d_reg <= rst;
  end

  // working copy of boot/debug byte: loaded on any reset, then software-owned
  always_ff @(posedge mclk) begin
    if (rst || ld_release) begin
      sw_ctrl <= store_reg[OPT_BOOT_DEBUG]; // [R01] [R19]
    end else if (sw_we) begin
      sw_ctrl <= sw_wdata; // [R01]
    end
  end

  // brown-out working copy only follows store on power-on
  always_ff @(posedge mclk) begin
    if ((rst || ld_release) && por_event) begin
      bod_work_reg <= store_reg[OPT_BROWNOUT]; // [R20]
    end
  end

  // restart block: software reset keeps the previous choice
  always_ff @(posedge mclk) begin
    if (rst && !soft_reset_event) begin
      boot_from_app_reg <= store_reg[OPT_BOOT_DEBUG][BIT_BOOT_SEL]; // [R03]
    end
  end

  // programmer port answer, one cycle after request
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rej_reg   <= 1'b0;
      rdata_reg <= FLASH_BLANK;
    end else begin
      ack_reg <= prog_req.op != OBL_OP_NONE;
      rej_reg <= is_prog && protected_w; // [R09] [R10]
      if (is_read) begin
        if (prog_req.to_option) begin
          rdata_reg <= (prog_req.index < 3'(OPT_COUNT)) ? store_reg[prog_req.index] : OPT_ERASED; // [R10]
        end else begin
          rdata_reg <= protected_w ? FLASH_BLANK : flash_rdata; // [R09]
        end
      end
    end
  end

  assign prog_ack         = ack_reg;
  assign prog_reject      = rej_reg;
  assign prog_rdata       = rdata_reg;
  assign flash_read_en    = is_read && !prog_req.to_option;
  assign flash_write_en   = is_prog && !prog_req.to_option && !protected_w; // [R09]
  assign flash_chip_erase = is_erase; // [R11]

  // in-app programming ignores read protection; brown-out may inhibit writes
  assign iap_blocked = iap_req && iap_is_write && options.bod_on
                       && options.bod_blocks_prog && supply_below_bod; // [R16] [R12]
  assign iap_grant   = iap_req && !iap_blocked;

  // decode of working copies and stored bytes
  always_comb begin
    options                  = '0;
    options.boot_from_app    = boot_from_app_reg;
    options.pwm_float_halt   = sw_ctrl[BIT_PWM_FLOAT];
    options.debug_port_on    = ~sw_ctrl[BIT_DEBUG_EN_N]; // [R06]
    options.reset_pin_is_rst = sw_ctrl[BIT_RESET_PIN]; // [R08]
    options.read_protected   = protected_w;
    unique casez (store_reg[OPT_LOADER_SIZE][BIT_LDR_HI:0]) // [R13]
      LDR_CODE_NONE: options.loader_kb = 5'h00;
      LDR_CODE_1K:   options.loader_kb = 5'h01;
      LDR_CODE_2K:   options.loader_kb = 5'h02;
      LDR_CODE_3K:   options.loader_kb = 5'h03;
      default:       options.loader_kb = LDR_KB_MAX;
    endcase
    options.app_kb          = FLASH_TOTAL_KB - options.loader_kb; // [R13]
    options.bod_on          = bod_work_reg[BIT_BOD_ON]; // [R14]
    unique case (bod_work_reg[BIT_BOD_LVL_HI:BIT_BOD_LVL_LO]) // [R15]
      2'h3:    options.bod_level_dv = BOD_MV_11;
      2'h2:    options.bod_level_dv = BOD_MV_10;
      2'h1:    options.bod_level_dv = BOD_MV_01;
      default: options.bod_level_dv = BOD_MV_00;
    endcase
    options.bod_reset_on    = bod_work_reg[BIT_BOD_RESET]; // [R17]
    options.bod_blocks_prog = bod_work_reg[BIT_BOD_SELFPROG]; // [R16]
    if (store_reg[OPT_WATCHDOG][BIT_WDT_HI:BIT_WDT_LO] == WDT_CODE_OFF) begin // [R18]
      options.wdt_mode = OBL_WDT_TIMER;
    end else if (store_reg[OPT_WATCHDOG][BIT_WDT_HI:BIT_WDT_LO] == WDT_CODE_STOPIDLE) begin
      options.wdt_mode = OBL_WDT_RESET_STOPIDLE;
    end else begin
      options.wdt_mode = OBL_WDT_RESET_RUN;
    end
  end

  // brown-out reset request
  assign brownout_reset = options.bod_on && options.bod_reset_on && supply_below_bod; // [R17]

  // hard fault: debug with port enabled only raises the flag
  assign hard_fault_reset = hard_fault && !(debug_mode && options.debug_port_on); // [R07]
  always_ff @(posedge mclk) begin
    if (rst) begin
      hf_flag_reg <= 1'b0;
    end else if (hard_fault) begin
      hf_flag_reg <= 1'b1; // [R07]
    end
  end
  assign hard_fault_flag = hf_flag_reg;

  // pwm pins float on halt only where pwm owns the pin
  always_comb begin
    pwm_out = pwm_out_raw;
    for (int c = 0; c < 8; c++) begin
      pwm_oe[c] = pwm_pin_select[c]
                  && !(debug_halt && options.pwm_float_halt); // [R04] [R05]
    end
  end
endmodule : obl_option_loader

// ==== verification/obl_loader_chk.sv ====
// checker for the option byte loader, bound to its top ports
`timescale 1ns/1ps
module obl_loader_chk
  import obl_pkg::*;
(
  // clock, reset and status inputs
  input wire logic                   mclk, rst, supply_below_bod, debug_mode, hard_fault, debug_halt,
  // programmer port
  input wire obl_pkg::obl_prog_req_s prog_req,
  input wire logic                   prog_ack, prog_reject,
  input wire logic [7:0]             prog_rdata, flash_rdata,
  // in-app port, software copy, pwm
  input wire logic                   iap_req, iap_is_write, iap_grant, iap_blocked, sw_we,
  input wire logic [7:0]             sw_wdata, sw_ctrl, pwm_pin_select, pwm_oe,
  // consumer side
  input wire obl_pkg::obl_options_s  options,
  input wire logic                   hard_fault_reset, hard_fault_flag, brownout_reset
);
  // one domain, so clocking and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // programmer read of the main array
  wire rd_flash = prog_req.op == OBL_OP_READ && !prog_req.to_option;

  property p_prot_rd; rd_flash && options.read_protected |=> prog_rdata == 8'hff; endproperty
  a_prot_rd: assert property (p_prot_rd) else $error("protected flash read not blank");
  property p_plain_rd; rd_flash && !options.read_protected |=> prog_rdata == $past(flash_rdata); endproperty
  a_plain_rd: assert property (p_plain_rd) else $error("flash read data wrong");
  property p_reject; prog_req.op == OBL_OP_PROGRAM && options.read_protected |=> prog_ack && prog_reject; endproperty
  a_reject: assert property (p_reject) else $error("protected program not refused");
  property p_erase; prog_req.op == OBL_OP_CHIP_ERASE |=> prog_ack && !prog_reject; endproperty
  a_erase: assert property (p_erase) else $error("chip erase refused");
  property p_iap; iap_req && iap_is_write && !supply_below_bod |-> iap_grant && !iap_blocked; endproperty
  a_iap: assert property (p_iap) else $error("in-app write not granted");
  property p_bod_blk;
    iap_req && iap_is_write && options.bod_on && options.bod_blocks_prog && supply_below_bod |-> iap_blocked && !iap_grant;
  endproperty
  a_bod_blk: assert property (p_bod_blk) else $error("low supply did not block in-app write");
  property p_hf; debug_mode && options.debug_port_on && hard_fault |-> !hard_fault_reset ##1 hard_fault_flag; endproperty
  a_hf: assert property (p_hf) else $error("debug hard fault handled wrongly");
  property p_pwm; debug_halt && options.pwm_float_halt |-> (pwm_oe & pwm_pin_select) == 8'h00; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm pins not floated on halt");
  property p_sw; sw_we && !$past(rst) |=> sw_ctrl == $past(sw_wdata); endproperty
  a_sw: assert property (p_sw) else $error("software write lost");
  property p_decode; options.debug_port_on == !sw_ctrl[4] && options.reset_pin_is_rst == sw_ctrl[2]; endproperty
  a_decode: assert property (p_decode) else $error("debug or reset pin decode wrong");
  property p_bodrst; options.bod_on && supply_below_bod |-> brownout_reset == options.bod_reset_on; endproperty
  a_bodrst: assert property (p_bodrst) else $error("brown-out reset wrong");
  // main scenarios reached
  c_prot: cover property (rd_flash && options.read_protected);
  c_blk: cover property (iap_blocked);
  c_hf: cover property (debug_mode && hard_fault && options.debug_port_on);
endmodule : obl_loader_chk
bind obl_option_loader obl_loader_chk u_chk (.mclk, .rst, .supply_below_bod, .debug_mode, .hard_fault, .debug_halt,
  .prog_req, .prog_ack, .prog_reject, .prog_rdata, .flash_rdata, .iap_req, .iap_is_write, .iap_grant, .iap_blocked,
  .sw_we, .sw_wdata, .sw_ctrl, .pwm_pin_select, .pwm_oe, .options, .hard_fault_reset, .hard_fault_flag,
  .brownout_reset);

// ==== verification/obl_prog_model.sv ====
// external programmer model on the loader's programming port
`timescale 1ns/1ps
module obl_prog_model
  import obl_pkg::*;
(
  // clock
  input  wire logic          mclk,
  // request and answer
  output obl_pkg::obl_prog_req_s prog_req,
  input  wire logic          prog_ack,
  input  wire logic          prog_reject,
  input  wire logic [7:0]    prog_rdata
);
  logic [7:0] got_rdata;   // data of the last answer
  logic       got_reject;  // refusal seen with it
  // writable bits per byte index; index 3 has none
  logic [7:0] wr_mask [5] = '{MASK_BOOT_DEBUG, MASK_LOADER_SIZE, MASK_BROWNOUT, MASK_UNUSED, MASK_WATCHDOG};
  initial prog_req = '{OBL_OP_NONE, 1'b0, 3'h0, 8'hff};
  // one request after gap idle cycles, op for one edge; ack and reject stand only
  // in the cycle after the taking edge, so they are caught just after that edge
  task automatic issue(input obl_op_e op, input logic opt, input logic [2:0] idx, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    prog_req <= '{op, opt, idx, opt ? (d | ~wr_mask[idx]) : d};
    @(posedge mclk);
    prog_req <= '{OBL_OP_NONE, ~opt, ~idx, ~d}; // released fields do not keep the old value
    #1;
    got_rdata = prog_rdata;
    got_reject = prog_reject;
  endtask : issue
endmodule : obl_prog_model

// ==== verification/test_option_byte_loader.sv ====
// self-checking bench for the option byte loader
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module test_option_byte_loader;
  import obl_pkg::*;
  logic mclk, rst, por_event, soft_reset_event, sw_we, supply_below_bod, debug_mode, hard_fault, debug_halt;
  logic iap_req, iap_is_write, prog_ack, prog_reject, flash_read_en, flash_write_en, flash_chip_erase;
  logic iap_grant, iap_blocked, hard_fault_reset, hard_fault_flag, brownout_reset;
  logic [7:0] flash_rdata, sw_wdata, sw_ctrl, pwm_pin_select, pwm_out_raw, prog_rdata, pwm_out, pwm_oe;
  obl_prog_req_s prog_req;
  obl_options_s  options;
  logic [7:0] st [5];   // model of the option store
  logic [7:0] w0, w2;   // model working copies
  logic       boot;     // model restart block
  int num_errors = 0;
  int tests_run = 0;
  int kb;
  obl_option_loader dut (.mclk, .rst, .por_event, .soft_reset_event, .prog_req, .prog_ack, .prog_reject,
    .prog_rdata, .flash_rdata, .flash_read_en, .flash_write_en, .flash_chip_erase, .iap_req, .iap_is_write,
    .iap_grant, .iap_blocked, .sw_we, .sw_wdata, .sw_ctrl, .supply_below_bod, .debug_mode, .hard_fault,
    .debug_halt, .pwm_pin_select, .pwm_out_raw, .options, .hard_fault_reset, .hard_fault_flag,
    .brownout_reset, .pwm_out, .pwm_oe);
  obl_prog_model pm (.mclk, .prog_req, .prog_ack, .prog_reject, .prog_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // status inputs wander each cycle
  always @(posedge mclk) begin
    {debug_mode, hard_fault, debug_halt, supply_below_bod, iap_req, iap_is_write} <= 6'($urandom);
    pwm_pin_select <= 8'($urandom);
    pwm_out_raw <= 8'($urandom);
  end
  task automatic prog(input logic [2:0] i, input logic [7:0] d);
    pm.issue(OBL_OP_PROGRAM, 1'b1, i, d, $urandom_range(2));
    `CHK(pm.got_reject, ~w0[1])
    if (w0[1]) st[i] = st[i] & (d | ~pm.wr_mask[i]);
  endtask : prog
  task automatic erase();
    pm.issue(OBL_OP_CHIP_ERASE, 1'b0, 3'h0, 8'h00, 0);
    st = '{default: 8'hff};
  endtask : erase
  task automatic do_reset(input logic p, input logic s);
    @(posedge mclk);
    rst <= 1'b1;
    por_event <= p;
    soft_reset_event <= s;
    @(posedge mclk);
    rst <= 1'b0;
    por_event <= 1'b0;
    soft_reset_event <= 1'b0;
    w0 = st[0];
    if (p) w2 = st[2];
    if (!s) boot = st[0][7];
    @(posedge mclk);
  endtask : do_reset
  task automatic read_back(input logic [2:0] i);
    pm.issue(OBL_OP_READ, 1'b1, i, 8'h00, 1);
    `CHK(pm.got_rdata, st[i])
  endtask : read_back
  task automatic flash_read();
    @(posedge mclk);
    flash_rdata <= 8'($urandom);
    pm.issue(OBL_OP_READ, 1'b0, 3'h0, 8'h00, 0);
    `CHK(pm.got_rdata, w0[1] ? flash_rdata : 8'hff)
  endtask : flash_read
  task automatic check_opts();
    #1;
    kb = st[1][2] ? 7 - st[1][2:0] : 4;
    `CHK(sw_ctrl, w0)
    `CHK(options.boot_from_app, boot)
    `CHK({options.pwm_float_halt, options.debug_port_on}, {w0[5], ~w0[4]})
    `CHK({options.reset_pin_is_rst, options.read_protected}, {w0[2], ~w0[1]})
    `CHK({options.loader_kb, options.app_kb}, {5'(kb), 5'(16 - kb)})
    `CHK({options.bod_on, options.bod_blocks_prog, options.bod_reset_on}, {w2[7], w2[3:2]})
    `CHK(options.bod_level_dv, w2[5] ? (w2[4] ? BOD_MV_11 : BOD_MV_10) : (w2[4] ? BOD_MV_01 : BOD_MV_00))
    `CHK(options.wdt_mode, st[4][7:4] == WDT_CODE_OFF ? OBL_WDT_TIMER :
      st[4][7:4] == WDT_CODE_STOPIDLE ? OBL_WDT_RESET_STOPIDLE : OBL_WDT_RESET_RUN)
    `CHK(pwm_out, pwm_out_raw)
    `CHK(pwm_oe, pwm_pin_select & ~{8{debug_halt & w0[5]}})
    `CHK(hard_fault_reset, hard_fault & ~(debug_mode & ~w0[4]))
    `CHK(brownout_reset, w2[7] & w2[2] & supply_below_bod)
    `CHK(iap_blocked, iap_req & iap_is_write & w2[7] & w2[3] & supply_below_bod)
    `CHK(iap_grant, iap_req & ~(iap_is_write & w2[7] & w2[3] & supply_below_bod))
  endtask : check_opts
  initial begin
    void'($urandom(43431));
    {rst, por_event, soft_reset_event, sw_we, sw_wdata, flash_rdata} = {3'b110, 17'h0};
    {debug_mode, hard_fault, debug_halt, supply_below_bod, iap_req, iap_is_write} = 6'h00;
    {pwm_pin_select, pwm_out_raw} = 16'h0000;
    {w0, w2, boot} = 17'h1ffff;
    erase(); // store starts unknown, so erase inside the power-on reset
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    por_event <= 1'b0;
    @(posedge mclk);
    check_opts();
    $display("blank option test done");
    for (int i = 0; i < 8; i++) begin
      erase();
      prog(3'h1, 8'(i));
      prog(3'h2, {i[2] | i[0], 1'($urandom), i[1:0], 4'($urandom)});
      prog(3'h4, i == 0 ? 8'hff : i == 1 ? 8'h5f : 8'($urandom));
      prog(3'h0, 8'($urandom) | 8'h02);
      do_reset(i[0], i[1] & ~i[0]);
      check_opts();
      for (int j = 0; j < 5; j++) read_back(3'(j));
      flash_read();
      $display("option set %0d test done", i);
    end
    erase();
    prog(3'h0, 8'hfd);
    do_reset(1'b1, 1'b0);
    check_opts();
    flash_read();
    prog(3'h2, 8'h00);
    read_back(3'h2);
    pm.issue(OBL_OP_PROGRAM, 1'b0, 3'h0, 8'h00, 0);
    `CHK(pm.got_reject, 1'b1)
    erase();
    do_reset(1'b1, 1'b0);
    check_opts();
    flash_read();
    $display("protection test done");
    prog(3'h2, 8'h0f);
    do_reset(1'b0, 1'b0);
    check_opts();
    @(posedge mclk);
    sw_we <= 1'b1;
    sw_wdata <= 8'($urandom);
    @(posedge mclk);
    sw_we <= 1'b0;
    w0 = sw_wdata;
    check_opts();
    do_reset(1'b0, 1'b1);
    check_opts();
    $display("reload test done");
    complete_run();
  end
  // about three hundred and fifty cycles expected; five thousand is a hang
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
endmodule : test_option_byte_loader
